// *** core/display_controller_control.sv ***
/*
  top-level control of the display controller: control and status
  registers, frame address queue, forced blanking, raster timing on the
  link clock and the colour outputs.
  assumes a free-running link clock, a fetch engine that presents a pixel
  on pixData in every link cycle with pixTake high, and software that
  keeps the documented order of programming.
*/
// Our own choice: the plain strobed port.
//
// Behaviour
// - writing the reset bit resets the controller but not the lookup table contents; bit reads zero
// - frame base writes beyond the queue maximum are dropped
// - queue maximum resets to one and must not exceed four
// - forced blanking drives colour to zero and blank active
// - blanking bit resets to one, applies at frame end or when stopped
// - depth code 00/01/10 gives 8/16/24 bits, 11 reserved, reset 24
// - 8-bit pixel without lookup is copied to all three colours
// - 16-bit splits 5/6/5, 24-bit direct, all left aligned
// - 8-bit pixel with lookup indexes the table for full colour
// - 16/24-bit with lookup maps each colour field separately
// - enabled controller fetches pixels and drives colour and timing
// - disabling finishes the frame, then stops; status shows it
// - stopped: counters at blank begin, blank on, syncs off, clocks off
// - pending count rises per base write, falls per address change
// - queue full at pending equals maximum; clears on new frame or stop
// - blank pending sets on blanking change, clears when applied or stop
`timescale 1ns/1ps
module display_controller_control
  import dc_pkg::*;
#(
  parameter logic [11:0] H_ACTIVE = 12'h280, // visible pixels per line
  parameter logic [11:0] H_SYNC_BEGIN = 12'h290, // first hsync pixel
  parameter logic [11:0] H_SYNC_END = 12'h2f0, // first pixel after hsync
  parameter logic [11:0] H_TOTAL = 12'h320, // pixels per line
  parameter logic [11:0] V_ACTIVE = 12'h1e0, // visible lines
  parameter logic [11:0] V_SYNC_BEGIN = 12'h1ea, // first vsync line
  parameter logic [11:0] V_SYNC_END = 12'h1ec, // first line after vsync
  parameter logic [11:0] V_TOTAL = 12'h20d, // lines per frame
  parameter int QUEUE_DEPTH = 4, // frame address slots, power of two
  parameter int ADDR_W = 32 // frame address width
)(
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [11:0] regAddr, // register byte address
  input wire logic [31:0] regWrData, // register write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [31:0] regRdData, // read data, cycle after regRd
  output logic [ADDR_W-1:0] frameAddr, // frame base address in use
  input wire logic clk_pix, // link clock
  input wire logic [23:0] pixData, // pixel from fetch, link domain
  output logic pixTake, // pixel consumed this link cycle
  output logic [9:0] rgbRed, // red output
  output logic [9:0] rgbGreen, // green output
  output logic [9:0] rgbBlue, // blue output
  output logic blankOut, // blanking, active high
  output logic hSyncOut, // horizontal sync, active high
  output logic vSyncOut, // vertical sync, active high
  output logic compositeSyncOut, // composite sync pulse, active high
  output logic dacClkOut, // converter clock, half link rate
  output logic dvoClkOut // digital video output clock, half link rate
);
  localparam int QW = $clog2(QUEUE_DEPTH);

  // system domain state
  logic softRst_r, rst;
  logic [2:0] qMax_r;
  logic blank_r, lutEn_r, enable_r;
  logic [1:0] depth_r;
  logic [2:0] pend_r, pendNxt, qLimit;
  logic full_r, blankPend_r, runPrev_r;
  logic [QW-1:0] wrPtr_r, rdPtr_r;
  logic [ADDR_W-1:0] addrQ [0:QUEUE_DEPTH-1];
  logic [ADDR_W-1:0] curAddr_r;
  logic [1:0] runS_r, blankS_r, lutAckS_r;
  logic [2:0] frmS_r;
  logic lutReq_r, lutBusy;
  logic [7:0] lutAddrH_r;
  logic [29:0] lutDataH_r;
  logic [2:0] holdCnt_r;
  logic pixRstReq_r;
  logic wrCtrl, wrBase, wrLut, push, pop, stopEvt, frameEvt;
  logic [31:0] ctrlWord, stsWord, rdData_r;

  // link domain state
  logic [1:0] rstS_r, enS_r, blankReqS_r, lutEnS_r, depthM_r, depthS_r;
  logic [2:0] lutReqS_r;
  logic rstPix, lutAck_r, running_r, blankEff_r, frmTgl_r;
  logic [11:0] hCnt_r, vCnt_r;
  logic atBoundary, advance;
  logic [1:0] actP_r, hsP_r, vsP_r;
  logic pixTake_r, blankOut_r, hSync_r, vSync_r, composite_sync_pulse_r;
  logic dacClk_r, dvoClk_r;
  logic [29:0] rgb_r;

  pix_map_if mapBus ();

  pixel_mapper u_map (
    .clk_pix(clk_pix),
    .m(mapBus)
  );

  // register strobes
  assign wrCtrl = regWr && (regAddr == OFS_CTRL);
  assign wrBase = regWr && (regAddr == OFS_FRAME_BASE);
  assign wrLut = regWr && (regAddr[11:10] == LUT_WINDOW) && !lutBusy;
  assign rst = srst | softRst_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      softRst_r <= 1'b0;
    end else begin
      softRst_r <= wrCtrl && regWrData[CTRL_RST_BIT];
    end
  end

  // control register; reset values
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      qMax_r <= QMAX_RST;
      blank_r <= BLANK_RST;
      depth_r <= DEPTH_RST;
      lutEn_r <= LUTEN_RST;
      enable_r <= EN_RST;
    end else if (wrCtrl) begin
      qMax_r <= regWrData[CTRL_QMAX_LSB +: 3];
      blank_r <= regWrData[CTRL_BLANK_BIT];
      depth_r <= regWrData[CTRL_DEPTH_LSB +: 2];
      lutEn_r <= regWrData[CTRL_LUTEN_BIT];
      enable_r <= regWrData[CTRL_EN_BIT];
    end
  end

  // status coming back from the link, two flops per level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      runS_r <= 2'h0;
      blankS_r <= {2{BLANK_RST}};
      frmS_r <= 3'h0;
      lutAckS_r <= 2'h0;
      runPrev_r <= 1'b0;
    end else begin
      runS_r <= {runS_r[0], running_r};
      blankS_r <= {blankS_r[0], blankEff_r};
      frmS_r <= {frmS_r[1:0], frmTgl_r};
      lutAckS_r <= {lutAckS_r[0], lutAck_r};
      runPrev_r <= runS_r[1];
    end
  end

  // stop seen when the running status falls
  assign stopEvt = runPrev_r && !runS_r[1];
  // a new frame buffer, when one is queued, is taken at each frame boundary
  assign frameEvt = frmS_r[2] ^ frmS_r[1];

  // a value above four is treated as four
  assign qLimit = (qMax_r > QMAX_LIMIT) ? QMAX_LIMIT : qMax_r;
  // writes past the limit are dropped
  assign push = wrBase && (pend_r < qLimit);
  // address in use changes on a queued entry
  assign pop = frameEvt && (pend_r != 3'h0);

  always_comb begin
    pendNxt = pend_r;
    if (push && !pop) begin
      pendNxt = pend_r + 3'h1;
    end else if (pop && !push) begin
      pendNxt = pend_r - 3'h1;
    end
  end

  // frame address queue
  always_ff @(posedge clk_sys) begin
    if (push) begin
      addrQ[wrPtr_r] <= regWrData[ADDR_W-1:0];
    end
  end

  // queue pointers and count; cleared on stop
  always_ff @(posedge clk_sys) begin
    if (rst || stopEvt) begin
      pend_r <= 3'h0;
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      pend_r <= pendNxt;
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end

  // current frame address; kept across a stop so fetch can resume
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      curAddr_r <= '0;
    end else if (pop) begin
      curAddr_r <= addrQ[rdPtr_r];
    end
  end

  // queue full; the set wins over the pop clear in the same cycle, a stop clear wins over the set
  always_ff @(posedge clk_sys) begin
    if (rst || stopEvt) begin
      full_r <= 1'b0;
    end else if (push && (pendNxt == qLimit)) begin
      full_r <= 1'b1;
    end else if (pop) begin
      full_r <= 1'b0;
    end
  end

  // blank pending; a change wins over the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blankPend_r <= 1'b0;
    end else if (wrCtrl && (regWrData[CTRL_BLANK_BIT] != blank_r)) begin
      blankPend_r <= 1'b1;
    end else if ((blankS_r[1] == blank_r) || stopEvt) begin
      blankPend_r <= 1'b0;
    end
  end

  // table writes are held and handed over by toggle; one in flight
  assign lutBusy = lutReq_r != lutAckS_r[1];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lutReq_r <= 1'b0;
      lutAddrH_r <= 8'h00;
      lutDataH_r <= 30'h0;
    end else if (wrLut) begin
      lutReq_r <= !lutReq_r;
      lutAddrH_r <= regAddr[9:2];
      lutDataH_r <= regWrData[29:0];
    end
  end

  // stretch the reset so the faster link side surely sees it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      holdCnt_r <= RST_HOLD;
      pixRstReq_r <= 1'b1;
    end else begin
      if (holdCnt_r != 3'h0) begin
        holdCnt_r <= holdCnt_r - 3'h1;
      end
      pixRstReq_r <= holdCnt_r != 3'h0;
    end
  end

  // register words
  always_comb begin
    ctrlWord = 32'h0;
    ctrlWord[CTRL_QMAX_LSB +: 3] = qMax_r;
    ctrlWord[CTRL_BLANK_BIT] = blank_r;
    ctrlWord[CTRL_DEPTH_LSB +: 2] = depth_r;
    ctrlWord[CTRL_LUTEN_BIT] = lutEn_r;
    ctrlWord[CTRL_EN_BIT] = enable_r;
    stsWord = 32'h0;
    stsWord[STS_PEND_LSB +: 3] = pend_r;
    stsWord[STS_BPEND_BIT] = blankPend_r;
    stsWord[STS_BLANK_BIT] = blankS_r[1];
    stsWord[STS_QFULL_BIT] = full_r;
    // running status, delayed one cycle so that it falls together
    // with the stop clear of the count, full and pending flags
    stsWord[STS_RUN_BIT] = runPrev_r;
  end

  // read port; data stands one cycle only, table reads as zero
  always_ff @(posedge clk_sys) begin
    if (rst || !regRd) begin
      rdData_r <= 32'h0;
    end else begin
      unique case (regAddr)
        OFS_CTRL: rdData_r <= ctrlWord;
        OFS_STATUS: rdData_r <= stsWord;
        OFS_FRAME_BASE: rdData_r <= 32'(curAddr_r);
        default: rdData_r <= 32'h0;
      endcase
    end
  end

  assign regRdData = rdData_r;
  assign frameAddr = curAddr_r;

  // link side: reset and settings two flops each, table request three
  always_ff @(posedge clk_pix) begin
    rstS_r <= {rstS_r[0], pixRstReq_r};
    enS_r <= {enS_r[0], enable_r};
    blankReqS_r <= {blankReqS_r[0], blank_r};
    lutEnS_r <= {lutEnS_r[0], lutEn_r};
    depthM_r <= depth_r;
    depthS_r <= depthM_r;
    lutReqS_r <= {lutReqS_r[1:0], lutReq_r};
  end
  assign rstPix = rstS_r[1];

  // table write handshake toward the mapper
  always_ff @(posedge clk_pix) begin
    if (rstPix) begin
      lutAck_r <= 1'b0;
    end else begin
      lutAck_r <= lutReqS_r[2];
    end
  end

  // settings are quasi-static: they only change while stopped
  assign mapBus.depth = depthS_r;
  assign mapBus.lutEn = lutEnS_r[1];
  assign mapBus.pix = pixData;
  assign mapBus.lutWe = lutReqS_r[2] ^ lutAck_r;
  assign mapBus.lutAddr = lutAddrH_r;
  assign mapBus.lutData = lutDataH_r;

  // the stopped position is also the frame boundary
  assign atBoundary = (hCnt_r == H_ACTIVE) && (vCnt_r == V_ACTIVE);
  assign advance = running_r && !(atBoundary && !enS_r[1]);

  always_ff @(posedge clk_pix) begin
    if (rstPix) begin
      hCnt_r <= H_ACTIVE;
      vCnt_r <= V_ACTIVE;
      running_r <= 1'b0;
      blankEff_r <= BLANK_RST;
      frmTgl_r <= 1'b0;
    end else begin
      if (!running_r) begin
        running_r <= enS_r[1];
        blankEff_r <= blankReqS_r[1];
      end else if (atBoundary) begin
        running_r <= enS_r[1];
        // applies at the end of a frame
        blankEff_r <= blankReqS_r[1];
        if (enS_r[1]) begin
          frmTgl_r <= !frmTgl_r;
        end
      end
      if (advance) begin
        if (hCnt_r == H_TOTAL - 12'h1) begin
          hCnt_r <= 12'h0;
          vCnt_r <= (vCnt_r == V_TOTAL - 12'h1) ? 12'h0 : vCnt_r + 12'h1;
        end else begin
          hCnt_r <= hCnt_r + 12'h1;
        end
      end
    end
  end

  // timing pipeline, aligned with the two-cycle pixel path
  always_ff @(posedge clk_pix) begin
    if (rstPix) begin
      actP_r <= 2'h0;
      hsP_r <= 2'h0;
      vsP_r <= 2'h0;
      pixTake_r <= 1'b0;
    end else begin
      actP_r <= {actP_r[0], running_r && (hCnt_r < H_ACTIVE)
        && (vCnt_r < V_ACTIVE)};
      hsP_r <= {hsP_r[0], running_r && (hCnt_r >= H_SYNC_BEGIN)
        && (hCnt_r < H_SYNC_END)};
      vsP_r <= {vsP_r[0], running_r && (vCnt_r >= V_SYNC_BEGIN)
        && (vCnt_r < V_SYNC_END)};
      pixTake_r <= running_r && (hCnt_r < H_ACTIVE) && (vCnt_r < V_ACTIVE);
    end
  end

  always_ff @(posedge clk_pix) begin
    if (rstPix) begin
      rgb_r <= 30'h0;
      blankOut_r <= 1'b1;
      hSync_r <= 1'b0;
      vSync_r <= 1'b0;
      composite_sync_pulse_r <= 1'b0;
    end else begin
      blankOut_r <= blankEff_r || !actP_r[1];
      rgb_r <= (blankEff_r || !actP_r[1]) ? 30'h0 : mapBus.color;
      hSync_r <= hsP_r[1];
      vSync_r <= vsP_r[1];
      composite_sync_pulse_r <= hsP_r[1] || vsP_r[1];
    end
  end

  // output clocks run only while the raster runs
  always_ff @(posedge clk_pix) begin
    if (rstPix || !running_r) begin
      dacClk_r <= 1'b0;
      dvoClk_r <= 1'b0;
    end else begin
      dacClk_r <= !dacClk_r;
      dvoClk_r <= !dvoClk_r;
    end
  end

  assign pixTake = pixTake_r;
  assign rgbRed = rgb_r[29:20];
  assign rgbGreen = rgb_r[19:10];
  assign rgbBlue = rgb_r[9:0];
  assign blankOut = blankOut_r;
  assign hSyncOut = hSync_r;
  assign vSyncOut = vSync_r;
  assign compositeSyncOut = composite_sync_pulse_r;
  assign dacClkOut = dacClk_r;
  assign dvoClkOut = dvoClk_r;
endmodule

// *** core/dc_pkg.sv ***
/*
  shared constants of the display control block: register offsets, field
  positions, reset values and the colour depth codes.
  assumes byte addresses on a 12-bit register port, one word per register.
*/
package dc_pkg;
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_FRAME_BASE = 12'h020;
  // lookup table window 0x400-0x7fc, selected by address bits 11:10
  localparam logic [1:0] LUT_WINDOW = 2'h1;

  // display_control fields
  localparam int CTRL_RST_BIT = 31;
  localparam int CTRL_QMAX_LSB = 24;
  localparam int CTRL_BLANK_BIT = 8;
  localparam int CTRL_DEPTH_LSB = 2;
  localparam int CTRL_LUTEN_BIT = 1;
  localparam int CTRL_EN_BIT = 0;

  // status word fields
  localparam int STS_PEND_LSB = 24;
  localparam int STS_BPEND_BIT = 11;
  localparam int STS_BLANK_BIT = 8;
  localparam int STS_QFULL_BIT = 4;
  localparam int STS_RUN_BIT = 0;

  // reset values
  localparam logic [2:0] QMAX_RST = 3'h1;
  localparam logic BLANK_RST = 1'b1;
  localparam logic [1:0] DEPTH_RST = 2'h2;
  localparam logic LUTEN_RST = 1'b0;
  localparam logic EN_RST = 1'b0;

  // largest queue depth software may ask for
  localparam logic [2:0] QMAX_LIMIT = 3'h4;
  // system cycles the link-side reset request is held
  localparam logic [2:0] RST_HOLD = 3'h3;

  typedef enum logic [1:0] {
    DEPTH_8 = 2'h0,
    DEPTH_16 = 2'h1,
    DEPTH_24 = 2'h2,
    DEPTH_RSVD = 2'h3
  } depth_t;
endpackage

// *** core/pix_map_if.sv ***
/*
  bundle between the raster control and the pixel mapper.
  assumes every signal belongs to the link clock domain.
*/
`timescale 1ns/1ps
interface pix_map_if;
  logic [1:0] depth;
  logic lutEn;
  logic [23:0] pix;
  logic [29:0] color;
  logic lutWe;
  logic [7:0] lutAddr;
  logic [29:0] lutData;
  modport ctrl (output depth, lutEn, pix, lutWe, lutAddr, lutData,
    input color);
  modport map (input depth, lutEn, pix, lutWe, lutAddr, lutData,
    output color);
endinterface

// *** core/pixel_mapper.sv ***
/*
  pixel to colour mapper with a 256-entry, 30-bit colour lookup table.
  assumes all inputs are on clk_pix; colour appears one cycle after pix.
*/
`timescale 1ns/1ps
module pixel_mapper
  import dc_pkg::*;
(
  input wire logic clk_pix, // link clock
  pix_map_if.map m // mapper side of the bundle
);
  logic [29:0] lut [0:255];

  // left-align an 8-bit colour on a 10-bit output
  function automatic logic [9:0] pad8(input logic [7:0] v);
    return {v, 2'h0};
  endfunction

  // each byte looked up on its own colour lane
  function automatic logic [29:0] look3(input logic [7:0] r,
    input logic [7:0] g, input logic [7:0] b);
    return {lut[r][29:20], lut[g][19:10], lut[b][9:0]};
  endfunction

  // table writes arrive already crossed into this domain
  always_ff @(posedge clk_pix) begin
    if (m.lutWe) begin
      lut[m.lutAddr] <= m.lutData;
    end
  end

  // colour mapping by depth and lookup enable
  always_ff @(posedge clk_pix) begin
    case (m.depth)
      DEPTH_8: begin
        if (m.lutEn) begin
          m.color <= lut[m.pix[7:0]];
        end else begin
          m.color <= {pad8(m.pix[7:0]), pad8(m.pix[7:0]),
            pad8(m.pix[7:0])};
        end
      end
      DEPTH_16: begin
        if (m.lutEn) begin
          m.color <= look3({3'h0, m.pix[15:11]}, {2'h0, m.pix[10:5]},
            {3'h0, m.pix[4:0]});
        end else begin
          m.color <= {m.pix[15:11], 5'h00, m.pix[10:5], 4'h0,
            m.pix[4:0], 5'h00};
        end
      end
      DEPTH_24: begin
        if (m.lutEn) begin
          m.color <= look3(m.pix[23:16], m.pix[15:8], m.pix[7:0]);
        end else begin
          m.color <= {pad8(m.pix[23:16]), pad8(m.pix[15:8]),
            pad8(m.pix[7:0])};
        end
      end
      default: begin
        m.color <= 30'h0; // reserved depth shows black
      end
    endcase
  end
endmodule

// *** bench/display_controller_control_properties.sv ***
/*
  port-level assertions for the display control block.
  assumes srst also quiets the link side and clk_pix runs free.
*/
`timescale 1ns/1ps
module display_controller_control_properties
  import dc_pkg::*;
#(
  parameter int ADDR_W = 32 // frame address width
)(
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset
  input wire logic [11:0] regAddr, // register address
  input wire logic [31:0] regWrData, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  input wire logic [31:0] regRdData, // read data
  input wire logic [ADDR_W-1:0] frameAddr, // address in use
  input wire logic clk_pix, // link clock
  input wire logic pixTake, // pixel consumed
  input wire logic [9:0] rgbRed, // red
  input wire logic [9:0] rgbGreen, // green
  input wire logic [9:0] rgbBlue, // blue
  input wire logic blankOut, // blank
  input wire logic hSyncOut, // hsync
  input wire logic vSyncOut, // vsync
  input wire logic compositeSyncOut, // composite sync
  input wire logic dacClkOut, // converter clock
  input wire logic dvoClkOut // video output clock
);
  // a control write with the reset bit set
  sequence s_rst_wr;
    regWr && regAddr == OFS_CTRL && regWrData[CTRL_RST_BIT];
  endsequence
  // output clock low for two link cycles means stopped
  sequence s_quiet;
    !dacClkOut ##1 !dacClkOut;
  endsequence

  AST_RST_BIT_LOW: assert property (
    @(posedge clk_sys) disable iff (srst)
    $past(regRd) && $past(regAddr) == OFS_CTRL |-> !regRdData[CTRL_RST_BIT])
    else $error("reset bit read back set");
  AST_RST_CLEARS: assert property (
    @(posedge clk_sys) disable iff (srst)
    s_rst_wr |-> ##[1:3] frameAddr == '0)
    else $error("reset bit did not clear the frame address");
  AST_STOP_QUIET: assert property (
    @(posedge clk_pix) disable iff (srst)
    s_quiet |-> blankOut && !hSyncOut && !vSyncOut && !compositeSyncOut)
    else $error("stopped raster not blank and quiet");
  AST_COMPOSITE_SYNC_PULSE_OR: assert property (
    @(posedge clk_pix) disable iff (srst)
    compositeSyncOut == (hSyncOut || vSyncOut))
    else $error("composite sync differs from its parts");
  AST_CLK_PAIR: assert property (
    @(posedge clk_pix) disable iff (srst)
    dacClkOut == dvoClkOut)
    else $error("output clocks disagree");
  AST_CLK_TOGGLE: assert property (
    @(posedge clk_pix) disable iff (srst)
    dacClkOut |=> !dacClkOut)
    else $error("output clock held high");
  AST_BLANK_BLACK: assert property (
    @(posedge clk_pix) disable iff (srst)
    pixTake |-> ##2 (!blankOut || {rgbRed, rgbGreen, rgbBlue} == 30'h0))
    else $error("colour present under blanking");
  AST_SYNC_IN_BLANK: assert property (
    @(posedge clk_pix) disable iff (srst)
    hSyncOut || vSyncOut |-> blankOut)
    else $error("sync outside blanking");
endmodule

bind display_controller_control display_controller_control_properties
  #(.ADDR_W(ADDR_W)) u_props (.clk_sys, .srst, .regAddr, .regWrData,
  .regWr, .regRd, .regRdData, .frameAddr, .clk_pix, .pixTake, .rgbRed,
  .rgbGreen, .rgbBlue, .blankOut, .hSyncOut, .vSyncOut, .compositeSyncOut,
  .dacClkOut, .dvoClkOut);

// *** bench/pixel_feed.sv ***
/*
  fetch-side stand-in that presents a pixel on every link cycle.
  assumes the bench changes the fill value only while stopped.
*/
`timescale 1ns/1ps
module pixel_feed (
  input wire logic clk_pix, // link clock
  input wire logic [23:0] fill, // pixel to present
  output logic [23:0] pixData // pixel to the block
);
  always_ff @(posedge clk_pix) begin
    pixData <= fill;
  end
endmodule

// *** bench/test_display_controller_control.sv ***
/*
  self-checking bench of the display control block.
  assumes a tiny raster so a frame lasts about twenty system cycles.
*/
`timescale 1ns/1ps
module test_display_controller_control
  import dc_pkg::*;
;
  logic clk_sys, srst, clk_pix, regWr, regRd, pixTake, blankOut;
  logic hSyncOut, vSyncOut, compositeSyncOut, dacClkOut, dvoClkOut;
  logic [11:0] regAddr;
  logic [31:0] regWrData, regRdData, frameAddr, s;
  logic [23:0] pixData, fill;
  logic [9:0] rgbRed, rgbGreen, rgbBlue;
  int err_count, samples_checked;

  // sync ends left at their defaults: beyond the tiny raster they run to
  // the wrap; hsync begin too, so only vsync marks the frame phase
  display_controller_control #(.H_ACTIVE(12'h004), .H_TOTAL(12'h008),
    .V_ACTIVE(12'h002), .V_SYNC_BEGIN(12'h003), .V_TOTAL(12'h004)) DUT (
    .clk_sys, .srst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .frameAddr, .clk_pix, .pixData, .pixTake, .rgbRed, .rgbGreen, .rgbBlue,
    .blankOut, .hSyncOut, .vSyncOut, .compositeSyncOut, .dacClkOut,
    .dvoClkOut);
  pixel_feed u_feed (.clk_pix, .fill, .pixData);

  // clocks; link phase offset so edges never coincide by design
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_pix = 1'b0;
    #1.3;
    forever #3 clk_pix = ~clk_pix;
  end

  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // bus cycles: one strobe cycle, read data taken the cycle after
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 s = regRdData;
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] q, input logic b,
      input logic [1:0] d, input logic l, input logic e);
    return {5'h0, q, 15'h0, b, 4'h0, d, l, e};
  endfunction
  function automatic logic [29:0] lut_val(input logic [7:0] i);
    return {i, 2'h1, ~i, 2'h2, i, 2'h3};
  endfunction
  // expected colour worked out from the mapping rules
  function automatic logic [29:0] exp_col(input logic [1:0] d,
      input logic l, input logic [23:0] p);
    logic [7:0] r, g, b;
    logic [29:0] lr, lg, lb;
    r = d == DEPTH_16 ? {3'h0, p[15:11]} : p[23:16];
    g = d == DEPTH_16 ? {2'h0, p[10:5]} : p[15:8];
    b = d == DEPTH_16 ? {3'h0, p[4:0]} : p[7:0];
    if (d == DEPTH_8) begin
      r = p[7:0];
      g = p[7:0];
    end
    lr = lut_val(r);
    lg = lut_val(g);
    lb = lut_val(b);
    if (d == DEPTH_RSVD) return 30'h0;
    if (l) return {lr[29:20], lg[19:10], lb[9:0]};
    if (d == DEPTH_16) return {r[4:0], 5'h0, g[5:0], 4'h0, b[4:0], 5'h0};
    return {r, 2'h0, g, 2'h0, b, 2'h0};
  endfunction
  // bounded polls; the sync lines are link signals seen from clk_sys
  task automatic wait_run(input logic v);
    int n;
    n = 0;
    do begin
      rd(OFS_STATUS);
      n++;
    end while (s[STS_RUN_BIT] !== v && n < 100);
    chk(s[STS_RUN_BIT], v);
  endtask
  task automatic wait_vs(input logic v);
    int n;
    for (n = 0; n < 100 && vSyncOut !== v; n++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic wait_addr(input logic [31:0] a);
    int n;
    for (n = 0; n < 200 && frameAddr !== a; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(frameAddr, a);
  endtask

  task automatic t_rst_vals();
    rd(OFS_CTRL);
    chk(s, 32'h0100_0108);
    rd(OFS_STATUS);
    chk(s, 32'h0000_0100);
    rd(12'h030);
    chk(s, 32'h0);
  endtask
  // table entries for every index the mapping pass uses
  task automatic t_lut();
    logic [7:0] idx [6] = '{8'hc3, 8'h14, 8'h2e, 8'h03, 8'h5a, 8'ha5};
    foreach (idx[k]) begin
      wr({LUT_WINDOW, idx[k], 2'h0}, {2'h0, lut_val(idx[k])});
      repeat (4) @(posedge clk_sys);
    end
  endtask
  // every depth code with the table off and on, changed while stopped
  task automatic t_map();
    int n;
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTRL, ctl(3'h1, 1'b0, i[2:1], i[0], 1'b0));
      wr(OFS_CTRL, ctl(3'h1, 1'b0, i[2:1], i[0], 1'b1));
      n = 0;
      do begin
        @(posedge clk_pix);
        #1 n++;
      end while (pixTake !== 1'b1 && n < 400);
      repeat (2) @(posedge clk_pix);
      #1 chk({blankOut, rgbRed, rgbGreen, rgbBlue},
        {1'b0, exp_col(i[2:1], i[0], fill)});
      wr(OFS_CTRL, ctl(3'h1, 1'b0, i[2:1], i[0], 1'b0));
      wait_run(1'b0);
    end
  endtask
  // forced blank at once when stopped, release only at frame end
  task automatic t_blank();
    wr(OFS_CTRL, ctl(3'h1, 1'b1, DEPTH_24, 1'b0, 1'b1));
    repeat (40) begin
      @(posedge clk_pix);
      #1 chk({blankOut, rgbRed, rgbGreen, rgbBlue}, {1'b1, 30'h0});
    end
    wait_vs(1'b1);
    wait_vs(1'b0);
    wr(OFS_CTRL, ctl(3'h1, 1'b0, DEPTH_24, 1'b0, 1'b1));
    rd(OFS_STATUS);
    chk({s[STS_BPEND_BIT], s[STS_BLANK_BIT]}, 2'h3);
    repeat (40) @(posedge clk_sys);
    rd(OFS_STATUS);
    chk({s[STS_BPEND_BIT], s[STS_BLANK_BIT]}, 2'h0);
    wr(OFS_CTRL, ctl(3'h1, 1'b0, DEPTH_24, 1'b0, 1'b0));
    wait_run(1'b0);
  endtask
  // depth-two queue: third entry dropped, pops at frame ends, stop
  task automatic t_queue();
    wr(OFS_CTRL, ctl(3'h2, 1'b0, DEPTH_24, 1'b0, 1'b0));
    wr(OFS_CTRL, ctl(3'h2, 1'b0, DEPTH_24, 1'b0, 1'b1));
    wait_vs(1'b1);
    wait_vs(1'b0);
    wr(OFS_FRAME_BASE, 32'h0000_1000);
    wr(OFS_FRAME_BASE, 32'h0000_2000);
    wr(OFS_FRAME_BASE, 32'h0000_3000);
    rd(OFS_STATUS);
    chk({s[26:24], s[STS_QFULL_BIT]}, 4'h5);
    wait_addr(32'h0000_1000);
    repeat (4) @(posedge clk_sys);
    rd(OFS_STATUS);
    chk({s[26:24], s[STS_QFULL_BIT]}, 4'h2);
    wr(OFS_FRAME_BASE, 32'h0000_4000);
    wait_addr(32'h0000_2000);
    wait_addr(32'h0000_4000);
    wr(OFS_FRAME_BASE, 32'h0000_5000);
    wr(OFS_CTRL, ctl(3'h2, 1'b0, DEPTH_24, 1'b0, 1'b0));
    rd(OFS_STATUS);
    chk(s[STS_RUN_BIT], 1'b1);
    wait_run(1'b0);
    chk({s[26:24], s[STS_BPEND_BIT], s[STS_QFULL_BIT]}, 5'h0);
    repeat (8) begin
      @(posedge clk_pix);
      #1 chk({dacClkOut, dvoClkOut, blankOut, hSyncOut, vSyncOut,
        compositeSyncOut}, 6'h08);
    end
  endtask
  // self-clearing reset bit while running with altered fields
  task automatic t_reset();
    wr(OFS_CTRL, ctl(3'h3, 1'b0, DEPTH_8, 1'b1, 1'b1));
    wait_run(1'b1);
    wr(OFS_CTRL, 32'h8000_0000);
    repeat (12) @(posedge clk_sys);
    rd(OFS_CTRL);
    chk(s, 32'h0100_0108);
    chk(frameAddr, 32'h0);
    rd(OFS_STATUS);
    chk(s, 32'h0000_0100);
  endtask

  initial begin
    srst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 12'h0;
    regWrData = 32'h0;
    fill = 24'h5aa5c3;
    err_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    t_rst_vals();
    t_lut();
    t_map();
    t_blank();
    t_queue();
    t_reset();
    complete_run();
  end
  // whole run needs well under this span; a hang ends as a failure
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule
